// ==== rtl/rra_arbiter.sv ====
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/100ps
// Functional notes
// - Compare hardware addresses digit by digit from the left; larger digit is higher.
// - On simultaneous start the unit with the lower address becomes primary.
// - Stopped primary hands over to running standby; standby stopped first means no switchover.
// - Cold auto start, peer primary, applications match, healthy: enter standby.
// - Cold auto start, peer primary, mismatch or unhealthy: enter offline.
// - Cold auto start, no remote primary, healthy: enter primary.
// - Cold auto start, no remote primary, unhealthy: enter offline.
// - Abnormal on power loss, halt, processor fault or sync link down.
// - Warm start restores stop or run; running resolves role like cold start.
// - Bits 00 with A primary, B standby: units swap roles, stay redundant.
// - Bits 01: A goes offline, B becomes primary within one task cycle.
// - Bits 10: A stays primary, B goes offline, no switchover.
// - Bits 11 leave roles unchanged.
// - A primary, B offline: 00, 10, 11 change nothing.
// - A primary, B offline, bits 01: A offline too, pair nonoperational.
// - Command word is written on primary and copied to standby each task cycle.
// - After commanded roles are taken, both run-command bits return to 1.
// - Run-command bit at 1 means run; normal state of both bits.
module rra_arbiter (
	// Clock and reset
	input  wire logic                         ref_clk_i,
	input  wire logic                         rst_n_i,
	// Register port
	input  wire logic [rra_pkg::ADDR_W-1:0]   addr_i,
	input  wire logic [rra_pkg::DATA_W-1:0]   wdata_i,
	input  wire logic                         wr_i,
	input  wire logic                         rd_i,
	output logic      [rra_pkg::DATA_W-1:0]   rdata_o,
	// Local control, same clock
	input  wire logic                         task_tick_i,
	input  wire logic                         cold_start_i,
	input  wire logic                         warm_start_i,
	input  wire logic                         auto_run_i,
	input  wire logic                         run_req_i,
	input  wire logic                         stop_req_i,
	input  wire logic                         unit_is_b_i,
	input  wire logic [rra_pkg::MAC_W-1:0]    local_mac_i,
	// Local pins, asynchronous
	input  wire logic                         app_match_i,
	input  wire logic [rra_pkg::HLTH_W-1:0]   hlth_i,
	// Peer link in, asynchronous
	input  wire logic [1:0]                   peer_role_i,
	input  wire logic [1:0]                   peer_cmd_i,
	input  wire logic                         peer_pend_i,
	input  wire logic [rra_pkg::MAC_W-1:0]    peer_mac_i,
	// Peer link out
	output logic      [1:0]                   role_o,
	output logic      [1:0]                   cmd_o,
	output logic                              pend_o,
	// Status
	output logic                              abnormal_o,
	output logic                              switchover_o
);

	rra_sync_if sync ();

	rra_pin_sync u_sync (
		.ref_clk_i   (ref_clk_i),
		.rst_n_i     (rst_n_i),
		.peer_role_i (peer_role_i),
		.peer_cmd_i  (peer_cmd_i),
		.peer_pend_i (peer_pend_i),
		.peer_mac_i  (peer_mac_i),
		.app_match_i (app_match_i),
		.hlth_i      (hlth_i),
		.sync        (sync.src)
	);

	logic mac_lower;

	rra_mac_cmp u_cmp (
		.local_mac_i   (local_mac_i),
		.peer_mac_i    (sync.peer_mac),
		.local_lower_o (mac_lower)
	);

	function automatic logic [1:0] role_code(input rra_pkg::rra_role_e r);
		case (r)
			rra_pkg::RRA_OFFLINE: return rra_pkg::ROLE_OFFLINE;
			rra_pkg::RRA_STANDBY: return rra_pkg::ROLE_STANDBY;
			rra_pkg::RRA_PRIMARY: return rra_pkg::ROLE_PRIMARY;
			default:              return rra_pkg::ROLE_STOP;
		endcase
	endfunction

	// ****************************************
	// State
	// ****************************************
	rra_pkg::rra_role_e          role_reg,  role_next;
	logic [1:0]                  cmd_reg,   cmd_next;
	logic                        done_reg,  done_next;
	logic                        pend_reg,  pend_next;
	logic                        swo_reg,   swo_next;
	logic [rra_pkg::DATA_W-1:0]  rdata_reg, rdata_next;

	logic healthy;
	logic peer_primary;
	logic peer_standby;
	logic mine;
	logic other;
	logic cmd_pending;

	assign healthy = sync.hlth[rra_pkg::H_POWER_OK] & ~sync.hlth[rra_pkg::H_HALT]
	               & ~sync.hlth[rra_pkg::H_CPU_FAULT] & sync.hlth[rra_pkg::H_LINK_UP];
	assign peer_primary = (sync.peer_role == rra_pkg::ROLE_PRIMARY);
	assign peer_standby = (sync.peer_role == rra_pkg::ROLE_STANDBY);
	// Own and partner run bits, {b, a} order
	assign mine  = unit_is_b_i ? cmd_reg[1] : cmd_reg[0];
	assign other = unit_is_b_i ? cmd_reg[0] : cmd_reg[1];
	assign cmd_pending = (cmd_reg != rra_pkg::CMD_DEFAULT) && !done_reg;

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		role_next  = role_reg;
		cmd_next   = cmd_reg;
		done_next  = done_reg;
		pend_next  = pend_reg;
		// Software command write
		if (wr_i && addr_i == rra_pkg::REG_CMD) begin
			cmd_next  = {wdata_i[rra_pkg::CMD_BIT_B], wdata_i[rra_pkg::CMD_BIT_A]};
			done_next = 1'b0;
		end

		if (cold_start_i) begin
			role_next = rra_pkg::RRA_STOP;
			pend_next = auto_run_i;
			cmd_next  = rra_pkg::CMD_DEFAULT;
			done_next = 1'b0;
		end else if (warm_start_i) begin
			role_next = rra_pkg::RRA_STOP;
			pend_next = (role_reg != rra_pkg::RRA_STOP);
		end else if (stop_req_i) begin
			role_next = rra_pkg::RRA_STOP;
			pend_next = 1'b0;
		end else if (run_req_i && role_reg == rra_pkg::RRA_STOP) begin
			pend_next = 1'b1;
		end else if (task_tick_i) begin
			// Non-primary follows primary's command word
			if (role_reg != rra_pkg::RRA_PRIMARY && peer_primary && sync.peer_cmd != cmd_reg) begin
				cmd_next  = sync.peer_cmd;
				done_next = 1'b0;
			end
			if (pend_reg) begin
				// Higher address waits until the peer is primary
				if (peer_primary) begin
					role_next = (sync.app_match && healthy) ? rra_pkg::RRA_STANDBY : rra_pkg::RRA_OFFLINE;
					pend_next = 1'b0;
				end else if (!healthy) begin
					role_next = rra_pkg::RRA_OFFLINE;
					pend_next = 1'b0;
				end else if (!sync.peer_pend || mac_lower) begin
					role_next = rra_pkg::RRA_PRIMARY;
					pend_next = 1'b0;
				end
			end else begin
				case (role_reg)
					rra_pkg::RRA_PRIMARY: begin
						if (!healthy) begin
							role_next = rra_pkg::RRA_OFFLINE;
						end else if (cmd_reg != rra_pkg::CMD_DEFAULT && done_reg) begin
							cmd_next  = rra_pkg::CMD_DEFAULT;
							done_next = 1'b0;
						end else if (cmd_pending && sync.peer_cmd == cmd_reg) begin
							// Act once the peer holds the same word
							done_next = 1'b1;
							if (!mine && other) begin
								role_next = rra_pkg::RRA_OFFLINE;
							end else if (!mine && !other && peer_standby) begin
								role_next = rra_pkg::RRA_STANDBY;
							end
						end
					end
					rra_pkg::RRA_STANDBY: begin
						if (!healthy) begin
							role_next = rra_pkg::RRA_OFFLINE;
						// A copied word lands in cmd_reg one tick later
						// Act only on the word the primary holds too
						end else if (cmd_pending && sync.peer_cmd == cmd_reg) begin
							done_next = 1'b1;
							if (!mine) begin
								role_next = other ? rra_pkg::RRA_OFFLINE : rra_pkg::RRA_PRIMARY;
							end
						end else if (!peer_primary) begin
							role_next = rra_pkg::RRA_PRIMARY;
						end
					end
					rra_pkg::RRA_OFFLINE: begin
						if (healthy && mine && peer_primary && sync.app_match && !cmd_pending) begin
							role_next = rra_pkg::RRA_STANDBY;
						end
					end
					default: begin
						role_next = role_reg;
					end
				endcase
			end
		end

	end

	// ****************************************
	// Role and command registers
	// ****************************************
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			role_reg <= rra_pkg::RRA_STOP;
			cmd_reg  <= rra_pkg::CMD_DEFAULT;
			done_reg <= 1'b0;
			pend_reg <= 1'b0;
		end else begin
			role_reg <= role_next;
			cmd_reg  <= cmd_next;
			done_reg <= done_next;
			pend_reg <= pend_next;
		end
	end

	// ****************************************
	// Switchover flag
	// ****************************************
	// A set in the same cycle as a software clear wins
	always_comb begin
		swo_next = swo_reg;
		if (wr_i && addr_i == rra_pkg::REG_STATUS && wdata_i[rra_pkg::ST_SWITCH]) begin
			swo_next = 1'b0;
		end
		if (role_reg == rra_pkg::RRA_STANDBY && role_next == rra_pkg::RRA_PRIMARY) begin
			swo_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			swo_reg <= 1'b0;
		end else begin
			swo_reg <= swo_next;
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	// Zero outside the cycle after a read strobe
	always_comb begin
		rdata_next = '0;
		if (rd_i) begin
			case (addr_i)
				rra_pkg::REG_CMD: begin
					rdata_next[rra_pkg::CMD_BIT_A] = cmd_reg[0];
					rdata_next[rra_pkg::CMD_BIT_B] = cmd_reg[1];
				end
				rra_pkg::REG_STATUS: begin
					rdata_next[rra_pkg::ST_ROLE_MSB:rra_pkg::ST_ROLE_LSB] = role_code(role_reg);
					rdata_next[rra_pkg::ST_RUN]      = (role_reg != rra_pkg::RRA_STOP);
					rdata_next[rra_pkg::ST_ABNORMAL] = ~healthy;
					rdata_next[rra_pkg::ST_SWITCH]   = swo_reg;
					rdata_next[rra_pkg::ST_UNIT_B]   = unit_is_b_i;
					rdata_next[rra_pkg::ST_PENDING]  = pend_reg;
				end
				default: begin
					rdata_next = '0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign rdata_o      = rdata_reg;
	assign role_o       = role_code(role_reg);
	assign cmd_o        = cmd_reg;
	assign pend_o       = pend_reg;
	assign abnormal_o   = ~healthy;
	assign switchover_o = swo_reg;

endmodule

// ==== rtl/rra_pkg.sv ====
package rra_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int          ADDR_W      = 4;
	localparam int          DATA_W      = 32;
	localparam logic [3:0]  REG_CMD     = 4'h0;
	localparam logic [3:0]  REG_STATUS  = 4'h4;

	// Run-command bit positions in the command word
	localparam int          CMD_BIT_A   = 1;
	localparam int          CMD_BIT_B   = 2;
	// Both units commanded to run, {b, a}
	localparam logic [1:0]  CMD_DEFAULT = 2'h3;

	// Status word fields
	localparam int          ST_ROLE_LSB = 0;
	localparam int          ST_ROLE_MSB = 1;
	localparam int          ST_RUN      = 2;
	localparam int          ST_ABNORMAL = 3;
	localparam int          ST_SWITCH   = 4;
	localparam int          ST_UNIT_B   = 5;
	localparam int          ST_PENDING  = 6;

	// ****************************************
	// Role codes seen on the peer link
	// ****************************************
	localparam logic [1:0]  ROLE_STOP    = 2'h0;
	localparam logic [1:0]  ROLE_OFFLINE = 2'h1;
	localparam logic [1:0]  ROLE_STANDBY = 2'h2;
	localparam logic [1:0]  ROLE_PRIMARY = 2'h3;

	// ****************************************
	// Hardware address
	// ****************************************
	localparam int          MAC_W       = 48;
	localparam int          DIGIT_W     = 4;
	localparam int          MAC_DIGITS  = MAC_W / DIGIT_W;

	// Health inputs: power ok, halted, cpu fault, sync link up
	localparam int          HLTH_W      = 4;
	localparam int          H_POWER_OK  = 0;
	localparam int          H_HALT      = 1;
	localparam int          H_CPU_FAULT = 2;
	localparam int          H_LINK_UP   = 3;

	typedef enum logic [1:0] {
		RRA_STOP,
		RRA_OFFLINE,
		RRA_STANDBY,
		RRA_PRIMARY
	} rra_role_e;

endpackage

// ==== rtl/rra_sync_if.sv ====
`timescale 1ns/100ps
interface rra_sync_if;
	logic [1:0]                  peer_role;
	logic [1:0]                  peer_cmd;
	logic                        peer_pend;
	logic [rra_pkg::MAC_W-1:0]   peer_mac;
	logic                        app_match;
	logic [rra_pkg::HLTH_W-1:0]  hlth;

	modport src (
		output peer_role,
		output peer_cmd,
		output peer_pend,
		output peer_mac,
		output app_match,
		output hlth
	);
	modport dst (
		input  peer_role,
		input  peer_cmd,
		input  peer_pend,
		input  peer_mac,
		input  app_match,
		input  hlth
	);
endinterface

// ==== rtl/rra_pin_sync.sv ====
`timescale 1ns/100ps
module rra_pin_sync (
	// Clock and reset
	input  wire logic                        ref_clk_i,
	input  wire logic                        rst_n_i,
	// Raw pins
	input  wire logic [1:0]                  peer_role_i,
	input  wire logic [1:0]                  peer_cmd_i,
	input  wire logic                        peer_pend_i,
	input  wire logic [rra_pkg::MAC_W-1:0]   peer_mac_i,
	input  wire logic                        app_match_i,
	input  wire logic [rra_pkg::HLTH_W-1:0]  hlth_i,
	// Synchronised view
	rra_sync_if.src                          sync
);

	localparam int W = 6 + rra_pkg::MAC_W + rra_pkg::HLTH_W;

	logic [W-1:0] raw;
	logic [W-1:0] stage1_reg;
	logic [W-1:0] stage2_reg;

	assign raw = {peer_role_i, peer_cmd_i, peer_pend_i, peer_mac_i, app_match_i, hlth_i};

	// ****************************************
	// Two-flop synchroniser per bit
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge ref_clk_i) begin
				if (!rst_n_i) begin
					stage1_reg[i] <= 1'b0;
					stage2_reg[i] <= 1'b0;
				end else begin
					stage1_reg[i] <= raw[i];
					stage2_reg[i] <= stage1_reg[i];
				end
			end
		end
	endgenerate

	assign {sync.peer_role, sync.peer_cmd, sync.peer_pend, sync.peer_mac, sync.app_match, sync.hlth} = stage2_reg;

endmodule

// ==== rtl/rra_mac_cmp.sv ====
`timescale 1ns/100ps
module rra_mac_cmp (
	// Addresses
	input  wire logic [rra_pkg::MAC_W-1:0] local_mac_i,
	input  wire logic [rra_pkg::MAC_W-1:0] peer_mac_i,
	// Result
	output logic                           local_lower_o
);

	// Leftmost differing hex digit decides
	function automatic logic is_lower(input logic [rra_pkg::MAC_W-1:0] a, input logic [rra_pkg::MAC_W-1:0] b);
		logic found;
		logic res;
		found = 1'b0;
		res   = 1'b0;
		for (int d = rra_pkg::MAC_DIGITS - 1; d >= 0; d--) begin
			if (!found && a[d*rra_pkg::DIGIT_W +: rra_pkg::DIGIT_W] != b[d*rra_pkg::DIGIT_W +: rra_pkg::DIGIT_W]) begin
				found = 1'b1;
				res   = a[d*rra_pkg::DIGIT_W +: rra_pkg::DIGIT_W] < b[d*rra_pkg::DIGIT_W +: rra_pkg::DIGIT_W];
			end
		end
		return res;
	endfunction

	assign local_lower_o = is_lower(local_mac_i, peer_mac_i);

endmodule

// ==== dv/rra_arbiter_checker.sv ====
`timescale 1ns/100ps
// ****************
// Arbiter port checks
// ****************
module rra_arbiter_checker (
	// Clock and reset
	input wire logic        ref_clk_i,
	input wire logic        rst_n_i,
	// Register port
	input wire logic [3:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	// Control and peer
	input wire logic        task_tick_i,
	input wire logic        cold_start_i,
	input wire logic        warm_start_i,
	input wire logic        stop_req_i,
	input wire logic        auto_run_i,
	input wire logic        unit_is_b_i,
	input wire logic [3:0]  hlth_i,
	input wire logic [1:0]  peer_role_i,
	input wire logic [1:0]  peer_cmd_i,
	// Outputs
	input wire logic [1:0]  role_o,
	input wire logic [1:0]  cmd_o,
	input wire logic        pend_o,
	input wire logic        abnormal_o,
	input wire logic        switchover_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire start_any = cold_start_i | warm_start_i | stop_req_i;
	wire any_ev    = task_tick_i | start_any;
	wire tk        = task_tick_i & ~start_any;
	wire bad_hlth  = ~hlth_i[0] | hlth_i[1] | hlth_i[2] | ~hlth_i[3];
	wire prim      = role_o == rra_pkg::ROLE_PRIMARY;

	a_read_idle: assert property (!rd_i |=> rdata_o == 32'h0)
		else $error("read data not zero when idle");
	a_start_stops: assert property (start_any |=> role_o == rra_pkg::ROLE_STOP)
		else $error("start or stop did not stop the unit");
	a_cold_pending: assert property (cold_start_i && auto_run_i |=> pend_o)
		else $error("cold start not pending");
	a_role_at_tick: assert property ($past(rst_n_i) && role_o != $past(role_o) |-> $past(any_ev))
		else $error("role changed off a task cycle");
	a_health_map: assert property ($past(rst_n_i, 2) && $past(rst_n_i) |-> abnormal_o == $past(bad_hlth, 2))
		else $error("abnormal flag does not follow health");
	a_switch_tick: assert property ($rose(switchover_o) |-> $past(task_tick_i))
		else $error("switchover flag set off a task cycle");
	a_cmd_write: assert property (wr_i && addr_i == rra_pkg::REG_CMD && prim && !any_ev
		|=> cmd_o == $past(wdata_i[2:1]))
		else $error("command write lost on primary");
	a_keep_run: assert property (tk && prim && cmd_o == 2'h3 && !abnormal_o |=> prim)
		else $error("primary left role with run bits set");
	a_swap_echo: assert property (tk && prim && cmd_o == 2'h0 && peer_cmd_i == 2'h0 && !abnormal_o
		&& peer_role_i == rra_pkg::ROLE_STANDBY |=> role_o == rra_pkg::ROLE_STANDBY)
		else $error("swap command not taken");
	a_drop_own: assert property (tk && prim && !unit_is_b_i && cmd_o == 2'h2 && peer_cmd_i == 2'h2
		|=> role_o == rra_pkg::ROLE_OFFLINE)
		else $error("own run bit cleared but not offline");
endmodule

// ==== dv/rra_peer_model.sv ====
`timescale 1ns/100ps
// ****************
// Peer controller model
// ****************
module rra_peer_model #(
	// Arbitrary address value
	parameter logic [47:0] PEER_MAC = 48'h0a0000000001
) (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        tick_i,
	input  wire logic        set_i,
	input  wire logic [1:0]  set_role_i,
	input  wire logic [1:0]  local_role_i,
	input  wire logic [1:0]  local_cmd_i,
	output logic      [1:0]  peer_role_o,
	output logic      [1:0]  peer_cmd_o,
	output logic             peer_pend_o,
	output logic      [47:0] peer_mac_o
);
	assign peer_pend_o = 1'b0;
	assign peer_mac_o  = PEER_MAC;
	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			peer_role_o <= rra_pkg::ROLE_STOP;
			peer_cmd_o  <= rra_pkg::CMD_DEFAULT;
		end else if (set_i) begin
			peer_role_o <= set_role_i;
			peer_cmd_o  <= rra_pkg::CMD_DEFAULT;
		end else if (tick_i && peer_role_o == rra_pkg::ROLE_STANDBY) begin
			if (local_role_i != rra_pkg::ROLE_PRIMARY)
				peer_role_o <= rra_pkg::ROLE_PRIMARY;
			else if (peer_cmd_o == 2'h0 && local_cmd_i == 2'h0)
				peer_role_o <= rra_pkg::ROLE_PRIMARY;
			peer_cmd_o <= local_cmd_i;
		end else if (tick_i && peer_role_o == rra_pkg::ROLE_PRIMARY)
			peer_cmd_o <= rra_pkg::CMD_DEFAULT;
	end
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/100ps
// ****************
// Testbench top
// ****************
module tb;
	logic        ref_clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic        task_tick_i = 1'b0, cold_start_i = 1'b0, warm_start_i = 1'b0;
	logic        auto_run_i = 1'b1, run_req_i = 1'b0, stop_req_i = 1'b0;
	logic        unit_is_b_i = 1'b0, app_match_i = 1'b1, set_peer = 1'b0, peer_pend_i;
	logic        pend_o, abnormal_o, switchover_o;
	logic [1:0]  set_role = 2'h0, peer_role_i, peer_cmd_i, role_o, cmd_o;
	logic [3:0]  addr_i = 4'h0, hlth_i = 4'h9;
	logic [31:0] wdata_i = 32'h0, rdata_o, d;
	logic [47:0] peer_mac_i, local_mac_i = 48'h0a0000000002;
	int          fails = 0, compares = 0;

	rra_arbiter dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .task_tick_i(task_tick_i),
		.cold_start_i(cold_start_i), .warm_start_i(warm_start_i), .auto_run_i(auto_run_i),
		.run_req_i(run_req_i), .stop_req_i(stop_req_i), .unit_is_b_i(unit_is_b_i),
		.local_mac_i(local_mac_i), .app_match_i(app_match_i), .hlth_i(hlth_i),
		.peer_role_i(peer_role_i), .peer_cmd_i(peer_cmd_i), .peer_pend_i(peer_pend_i),
		.peer_mac_i(peer_mac_i), .role_o(role_o), .cmd_o(cmd_o), .pend_o(pend_o),
		.abnormal_o(abnormal_o), .switchover_o(switchover_o));
	rra_peer_model peer_m (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tick_i(task_tick_i),
		.set_i(set_peer), .set_role_i(set_role), .local_role_i(role_o), .local_cmd_i(cmd_o),
		.peer_role_o(peer_role_i), .peer_cmd_o(peer_cmd_i), .peer_pend_o(peer_pend_i),
		.peer_mac_o(peer_mac_i));

	always #2 ref_clk_i = ~ref_clk_i;

	task automatic chk(input string n, input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %s exp %h got %h", n, exp, got);
		end
	endtask
	task automatic start(input logic warm);
		@(posedge ref_clk_i);
		cold_start_i <= !warm;
		warm_start_i <= warm;
		@(posedge ref_clk_i);
		cold_start_i <= 1'b0;
		warm_start_i <= 1'b0;
	endtask
	// Ticks spaced so synced peer values settle
	task automatic tick(input int n);
		repeat (n) begin
			repeat (5) @(posedge ref_clk_i);
			task_tick_i <= 1'b1;
			@(posedge ref_clk_i);
			task_tick_i <= 1'b0;
		end
		#1;
	endtask
	task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] v);
		@(posedge ref_clk_i);
		wr_i <= w;
		rd_i <= !w;
		addr_i <= a;
		wdata_i <= v;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	task automatic peer(input logic [1:0] r);
		@(posedge ref_clk_i);
		set_peer <= 1'b1;
		set_role <= r;
		@(posedge ref_clk_i);
		set_peer <= 1'b0;
	endtask
	task automatic pair;
		peer(rra_pkg::ROLE_STOP);
		start(1'b0);
		#1 chk("pend", pend_o, 32'h1);
		tick(1);
		chk("role", role_o, rra_pkg::ROLE_PRIMARY);
		peer(rra_pkg::ROLE_STANDBY);
	endtask
	task automatic t_faults;
		logic [3:0] bad [4] = '{4'h8, 4'hb, 4'hd, 4'h1};
		foreach (bad[i]) begin
			@(posedge ref_clk_i);
			hlth_i <= bad[i];
			start(1'b0);
			tick(1);
			chk("abn", abnormal_o, 32'h1);
			chk("role", role_o, rra_pkg::ROLE_OFFLINE);
		end
		@(posedge ref_clk_i);
		hlth_i <= 4'h9;
	endtask
	task automatic t_keep;
		pair();
		start(1'b1);
		tick(1);
		chk("warm", role_o, rra_pkg::ROLE_PRIMARY);
		peer(rra_pkg::ROLE_STANDBY);
		acc(1'b1, rra_pkg::REG_CMD, 32'h6);
		tick(2);
		chk("role", role_o, rra_pkg::ROLE_PRIMARY);
		acc(1'b1, rra_pkg::REG_CMD, 32'h2);
		tick(2);
		chk("role", role_o, rra_pkg::ROLE_PRIMARY);
		chk("swo", switchover_o, 32'h0);
		acc(1'b1, rra_pkg::REG_CMD, 32'h4);
		tick(2);
		chk("role", role_o, rra_pkg::ROLE_OFFLINE);
	endtask
	task automatic t_swap;
		pair();
		acc(1'b1, rra_pkg::REG_CMD, 32'h0);
		tick(2);
		chk("role", role_o, rra_pkg::ROLE_STANDBY);
		tick(2);
		chk("cmd", cmd_o, 32'h3);
		acc(1'b0, rra_pkg::REG_STATUS, 32'h0);
		chk("status", d[1:0], rra_pkg::ROLE_STANDBY);
	endtask
	task automatic t_standby;
		@(posedge ref_clk_i);
		unit_is_b_i <= 1'b1;
		app_match_i <= 1'b0;
		peer(rra_pkg::ROLE_PRIMARY);
		start(1'b0);
		tick(1);
		chk("role", role_o, rra_pkg::ROLE_OFFLINE);
		@(posedge ref_clk_i);
		app_match_i <= 1'b1;
		start(1'b0);
		tick(1);
		chk("role", role_o, rra_pkg::ROLE_STANDBY);
		acc(1'b1, rra_pkg::REG_CMD, 32'h0);
		tick(1);
		chk("cmd", cmd_o, 32'h3);
		chk("role", role_o, rra_pkg::ROLE_STANDBY);
		peer(rra_pkg::ROLE_STOP);
		tick(1);
		chk("role", role_o, rra_pkg::ROLE_PRIMARY);
		chk("swo", switchover_o, 32'h1);
		acc(1'b1, rra_pkg::REG_STATUS, 32'h10);
		acc(1'b0, rra_pkg::REG_STATUS, 32'h0);
		chk("swo clear", d[4], 32'h0);
	endtask
	task automatic end_of_test;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		acc(1'b0, 4'h8, 32'h0);
		chk("unmapped", d, 32'h0);
		chk("role", role_o, 32'h0);
		chk("cmd", cmd_o, 32'h3);
		$display("reset test done");
		t_faults();
		$display("fault test done");
		t_keep();
		$display("command test done");
		t_swap();
		$display("swap test done");
		t_standby();
		$display("standby test done");
		end_of_test();
	end
	initial begin
		#40000;
		fails++;
		end_of_test();
	end
endmodule

bind rra_arbiter rra_arbiter_checker u_chk (.*);
